/* File: logic/dcm_coil_map.sv */
/*
 * Coil map and holding-register scaling of the drive network slave.
 * Assumes the frame decoder upstream hands over one coil request and
 * one holding-register write per cycle at most, already checked.
 */
`timescale 1ns/1ns

// What this block does and what it expects of the master
// (R01) Write-activity coil shows internal write in progress
// (R02) Five read-only coils report serial link errors
// (R03) Error coils stick until error reset
// (R04) Error reset accepted while the drive runs
// (R05) Terminal coil on if terminal or net on
// (R06) Physical terminal wins over network value
// (R07) Terminal on then off clears the coil
// (R08) Source coils read 1 for operator panel
// (R09) Motor coil reads 1 for second motor
// (R10) Received register values divided by 10/100
// (R11) Master scales engineering values to integers
// (R12) Master keeps written values within range
// (R13) Wide values split high then low registers
// (R14) Register LSB is a fixed engineering quantity
// (R15) Writes accepted only on read-write entries
// (R16) Each coil address holds one bit
// (R17) Reserved and unmapped coils are inaccessible
// (R18) Status coils return live value when read

module dcm_coil_map (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire dcm_pkg::dcm_coilreq_s coilReq,
    output dcm_pkg::dcm_coilrsp_s      coilRsp,
    input  wire dcm_pkg::dcm_drive_s   driveStatus,
    input  wire dcm_pkg::dcm_commerr_s commErrEvent,
    input  wire logic                  errReset,
    input  wire logic [6:0]            termIn,
    output logic [6:0]                 termEffective,
    input  wire dcm_pkg::dcm_regwr_s   regWr,
    output logic                       valueValid,
    output logic [15:0]                valueAddr,
    output logic [31:0]                valueData
);
    import dcm_pkg::*;

    // ------------------------------------------------------------
    // Communication error flags
    // ------------------------------------------------------------
    dcm_commerr_s errFlags_q;
    dcm_commerr_s errFlags_d;

    // A new error in the clearing cycle survives the reset
    always_comb begin
        errFlags_d = errFlags_q;
        if (errReset) begin
            errFlags_d = '0;                               // [R03] [R04]
        end
        errFlags_d = errFlags_d | commErrEvent;           // [R02] [R03]
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            errFlags_q <= '0;
        end else begin
            errFlags_q <= errFlags_d;
        end
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic [DCM_STAT_COUNT-1:0] coilVec;
    logic [DCM_STAT_COUNT-1:0] statHitVec;
    logic                      statHit;
    logic                      statVal;
    logic                      termHit;
    logic [2:0]                termIdx;
    logic [15:0]               termOffset;

    assign coilVec = {errFlags_q, driveStatus};           // [R01] [R08] [R09]

    // One comparator per status coil; reserved gaps never match
    genvar gi;
    generate
        for (gi = 0; gi < DCM_STAT_COUNT; gi++) begin : gStat
            assign statHitVec[gi] = (coilReq.addr == DCM_STAT_OFF[gi]);
        end
    endgenerate

    assign statHit    = |statHitVec;                      // [R16] [R17]
    assign statVal    = |(statHitVec & coilVec);          // [R18]
    assign termHit    = (coilReq.addr >= DCM_TERM_FIRST) &&
                        (coilReq.addr <= DCM_TERM_LAST);
    assign termOffset = coilReq.addr - DCM_TERM_FIRST;
    assign termIdx    = termOffset[2:0];

    // ------------------------------------------------------------
    // Input terminal coils
    // ------------------------------------------------------------
    logic [6:0] netCoil_q;
    logic [6:0] termPrev_q;
    logic [6:0] termFall;

    assign termFall = termPrev_q & ~termIn;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            termPrev_q <= '0;
        end else begin
            termPrev_q <= termIn;
        end
    end

    // A local on-off pulse releases a coil a lost master left set;
    // the release beats a network write landing in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            netCoil_q <= '0;
        end else begin
            for (int i = 0; i < DCM_TERM_COUNT; i++) begin
                if (termFall[i]) begin
                    netCoil_q[i] <= 1'b0;                 // [R07]
                end else if (coilReq.valid && coilReq.write &&
                             termHit && termIdx == 3'(i)) begin
                    netCoil_q[i] <= coilReq.wdata;        // [R15]
                end
            end
        end
    end

    // Terminal on forces the coil on whatever the network wrote
    assign termEffective = termIn | netCoil_q;            // [R05] [R06]

    // ------------------------------------------------------------
    // Coil response
    // ------------------------------------------------------------
    dcm_coilrsp_s rsp_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rsp_q <= '0;
        end else begin
            rsp_q.valid <= coilReq.valid;
            if (coilReq.valid) begin
                if (termHit) begin
                    rsp_q.err  <= 1'b0;
                    rsp_q.data <= termEffective[termIdx]; // [R05]
                end else if (statHit && !coilReq.write) begin
                    rsp_q.err  <= 1'b0;
                    rsp_q.data <= statVal;                // [R18]
                end else begin
                    // Write to read-only, reserved or past the map end
                    rsp_q.err  <= 1'b1;                   // [R15] [R17]
                    rsp_q.data <= 1'b0;
                end
            end
        end
    end

    assign coilRsp = rsp_q;

    // ------------------------------------------------------------
    // Holding register scaling
    // ------------------------------------------------------------
    dcm_pair_e   pair_q;
    logic [15:0] hiData_q;
    logic [15:0] hiAddr_q;
    logic [31:0] combined;
    logic        combineNow;
    logic        valueValid_q;
    logic [15:0] valueAddr_q;
    logic [31:0] valueData_q;

    // A low half with no matching high half is taken as high = 0
    assign combineNow = regWr.valid && !(regWr.wide && regWr.high);
    assign combined   = (regWr.wide && pair_q == DCM_PAIR_HIGH &&
                         regWr.addr == hiAddr_q + 16'h0001) ?
                        {hiData_q, regWr.data} :          // [R13]
                        {16'h0000, regWr.data};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pair_q   <= DCM_PAIR_IDLE;
            hiData_q <= DCM_ADDR_RST;
            hiAddr_q <= DCM_ADDR_RST;
        end else begin
            case (pair_q)
                DCM_PAIR_IDLE: begin
                    if (regWr.valid && regWr.wide && regWr.high) begin
                        pair_q   <= DCM_PAIR_HIGH;
                        hiData_q <= regWr.data;           // [R13]
                        hiAddr_q <= regWr.addr;
                    end
                end
                DCM_PAIR_HIGH: begin
                    if (regWr.valid && regWr.wide && regWr.high) begin
                        hiData_q <= regWr.data;
                        hiAddr_q <= regWr.addr;
                    end else if (regWr.valid) begin
                        pair_q <= DCM_PAIR_IDLE;
                    end
                end
                default: begin
                    pair_q <= DCM_PAIR_IDLE;
                end
            endcase
        end
    end

    // Constant divisors keep this a fixed-width datapath; the LSB of
    // the network value is 1/10 or 1/100 of an internal unit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            valueValid_q <= 1'b0;
            valueAddr_q  <= DCM_ADDR_RST;
            valueData_q  <= DCM_VALUE_RST;
        end else begin
            valueValid_q <= combineNow;
            if (combineNow) begin
                valueAddr_q <= regWr.addr;
                valueData_q <= regWr.div100 ?
                               combined / DCM_SCALE_100 :   // [R10] [R14]
                               combined / DCM_SCALE_10;
            end
        end
    end

    assign valueValid = valueValid_q;
    assign valueAddr  = valueAddr_q;
    assign valueData  = valueData_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_err_sticky: assert property (                     // [R03]
        @(posedge clk) disable iff (!rst_n)
        (errFlags_q != '0 && !errReset) |=>
            ((errFlags_q & $past(errFlags_q)) == $past(errFlags_q)))
        else $error("error coil dropped without error reset");

    chk_err_clear: assert property (                      // [R04]
        @(posedge clk) disable iff (!rst_n)
        (errReset && commErrEvent == '0) |=> (errFlags_q == '0))
        else $error("error reset did not clear error coils");

    chk_err_set: assert property (                        // [R02]
        @(posedge clk) disable iff (!rst_n)
        (commErrEvent.crc_error_flag ##1
         (coilReq.valid && !coilReq.write &&
          coilReq.addr == DCM_STAT_OFF[28])) |=> rsp_q.data)
        else $error("crc error coil not reported");

    chk_term_prio: assert property (                      // [R06]
        @(posedge clk) disable iff (!rst_n)
        (termIn != '0) |-> ((termEffective & termIn) == termIn))
        else $error("terminal on but coil reads off");

    chk_term_release: assert property (                   // [R07]
        @(posedge clk) disable iff (!rst_n)
        (termFall != '0) |=> ((netCoil_q & $past(termFall)) == '0))
        else $error("terminal off did not release coil");

    chk_write_flag: assert property (                     // [R01]
        @(posedge clk) disable iff (!rst_n)
        (coilReq.valid && !coilReq.write &&
         coilReq.addr == DCM_OFF_WRITE) |=>
            (rsp_q.valid && !rsp_q.err &&
             rsp_q.data == $past(driveStatus.write_in_progress_flag)))
        else $error("write-activity coil wrong");

    chk_src_coils: assert property (                      // [R08]
        @(posedge clk) disable iff (!rst_n)
        (coilReq.valid && !coilReq.write &&
         coilReq.addr == DCM_OFF_FREQ) |=>
            (rsp_q.data == $past(driveStatus.frequency_command_source)))
        else $error("frequency source coil wrong");

    chk_motor_coil: assert property (                     // [R09]
        @(posedge clk) disable iff (!rst_n)
        (coilReq.valid && !coilReq.write &&
         coilReq.addr == DCM_OFF_MOTOR) |=>
            (rsp_q.data == $past(driveStatus.second_motor_selected)))
        else $error("motor selection coil wrong");

    chk_ro_refuse: assert property (                      // [R15]
        @(posedge clk) disable iff (!rst_n)
        (coilReq.valid && coilReq.write && !termHit) |=>
            (rsp_q.valid && rsp_q.err))
        else $error("write to read-only coil accepted");

    chk_unmapped: assert property (                       // [R17]
        @(posedge clk) disable iff (!rst_n)
        (coilReq.valid && coilReq.addr >= DCM_MAP_END) |=>
            (rsp_q.err && !rsp_q.data))
        else $error("unmapped coil not refused");

    chk_scale_div: assert property (                      // [R10]
        @(posedge clk) disable iff (!rst_n)
        (combineNow && !regWr.div100 && combined < 32'h0100_0000) |=>
            (valueValid &&
             valueData * DCM_SCALE_10 <= $past(combined) &&
             $past(combined) < valueData * DCM_SCALE_10 + DCM_SCALE_10))
        else $error("scaled value not divided by ten");

    chk_pair_join: assert property (                      // [R13]
        @(posedge clk) disable iff (!rst_n)
        (regWr.valid && regWr.wide && regWr.high) ##1
        (regWr.valid && regWr.wide && !regWr.high &&
         regWr.addr == $past(regWr.addr) + 16'h0001) |->
            (combined[31:16] == $past(regWr.data)))
        else $error("high and low halves not joined");

    chk_rsp_answer: assert property (                     // [R16]
        @(posedge clk) disable iff (!rst_n)
        coilReq.valid |=> coilRsp.valid)
        else $error("coil request not answered");

    chk_rsp_pulse: assert property (                      // [R16]
        @(posedge clk) disable iff (!rst_n)
        !coilReq.valid |=> !coilRsp.valid)
        else $error("coil answer without request");

    chk_err_no_data: assert property (                    // [R17]
        @(posedge clk) disable iff (!rst_n)
        (coilRsp.valid && coilRsp.err) |-> !coilRsp.data)
        else $error("refused coil returned data");

    chk_low_refused: assert property (                    // [R17]
        @(posedge clk) disable iff (!rst_n)
        (coilReq.valid && coilReq.addr < DCM_TERM_FIRST) |=> coilRsp.err)
        else $error("lower coil not refused");

    chk_term_write: assert property (                     // [R15]
        @(posedge clk) disable iff (!rst_n)
        (coilReq.valid && coilReq.write && termHit && termFall == '0) |=>
            (netCoil_q[$past(termIdx)] == $past(coilReq.wdata)))
        else $error("terminal coil write not stored");

    chk_term_read: assert property (                      // [R05]
        @(posedge clk) disable iff (!rst_n)
        (coilReq.valid && termHit) |=>
            (!coilRsp.err && coilRsp.data == $past(termEffective[termIdx])))
        else $error("terminal coil read wrong");

    chk_run_src: assert property (                        // [R08]
        @(posedge clk) disable iff (!rst_n)
        (coilReq.valid && !coilReq.write && coilReq.addr == DCM_OFF_RUN) |=>
            (coilRsp.data == $past(driveStatus.run_command_source)))
        else $error("run source coil wrong");

    chk_err_setwins: assert property (                    // [R03]
        @(posedge clk) disable iff (!rst_n)
        (errReset && commErrEvent != '0) |=>
            ((errFlags_q & $past(commErrEvent)) == $past(commErrEvent)))
        else $error("error lost to a same-cycle reset");

    chk_high_quiet: assert property (                     // [R13]
        @(posedge clk) disable iff (!rst_n)
        (regWr.valid && regWr.wide && regWr.high) |=> !valueValid)
        else $error("value strobe on a high half");

    chk_value_strobe: assert property (                   // [R10]
        @(posedge clk) disable iff (!rst_n)
        (regWr.valid && !(regWr.wide && regWr.high)) |=>
            (valueValid && valueAddr == $past(regWr.addr)))
        else $error("value strobe or address missing");

    chk_scale_hundred: assert property (                  // [R10]
        @(posedge clk) disable iff (!rst_n)
        (regWr.valid && regWr.div100 && !regWr.wide) |=>
            (valueData == {16'h0000, $past(regWr.data)} / DCM_SCALE_100))
        else $error("scaled value not divided by hundred");

endmodule

/* File: logic/dcm_pkg.sv */
/*
 * Shared constants and carrier types for the drive coil map block.
 * Assumes a single clock domain and a synchronous, active-low reset.
 */
package dcm_pkg;

    // ------------------------------------------------------------
    // Coil map layout
    // ------------------------------------------------------------
    localparam int          DCM_STAT_COUNT = 33;
    localparam int          DCM_DRIVE_BITS = 28;
    localparam int          DCM_TERM_COUNT = 7;
    localparam logic [15:0] DCM_TERM_FIRST = 16'h0007;
    localparam logic [15:0] DCM_TERM_LAST  = 16'h000D;
    localparam logic [15:0] DCM_MAP_END    = 16'h0059;
    localparam logic [15:0] DCM_OFF_WRITE  = 16'h0049;
    localparam logic [15:0] DCM_OFF_FREQ   = 16'h0054;
    localparam logic [15:0] DCM_OFF_RUN    = 16'h0055;
    localparam logic [15:0] DCM_OFF_MOTOR  = 16'h0056;

    // Index i is bit i of {commerr, drive}; gaps are reserved coils
    localparam logic [15:0] DCM_STAT_OFF [DCM_STAT_COUNT] = '{
        16'h002D, 16'h002E, 16'h002F, 16'h0032, 16'h0033, 16'h0034,
        16'h0035, 16'h0036, 16'h003A, 16'h003B, 16'h003C, 16'h003D,
        16'h003E, 16'h003F, 16'h0040, 16'h0041, 16'h0045, 16'h0046,
        16'h0047, 16'h0048, 16'h0049, 16'h0050, 16'h0051, 16'h0053,
        16'h0054, 16'h0055, 16'h0056, 16'h0058, 16'h004A, 16'h004B,
        16'h004C, 16'h004D, 16'h004E
    };

    // ------------------------------------------------------------
    // Holding register scaling and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] DCM_SCALE_10  = 32'h0000_000A;
    localparam logic [31:0] DCM_SCALE_100 = 32'h0000_0064;
    localparam logic [31:0] DCM_VALUE_RST = 32'h0000_0000;
    localparam logic [15:0] DCM_ADDR_RST  = 16'h0000;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    // Declared from highest coil offset down so bit 0 is 002Dh
    typedef struct packed {
        logic gate_suppress_monitor;
        logic second_motor_selected;
        logic run_command_source;
        logic frequency_command_source;
        logic option_board_lost_flag;
        logic window_compare_current_flag;
        logic window_compare_voltage_flag;
        logic write_in_progress_flag;
        logic major_failure_flag;
        logic reverse_rotation_flag;
        logic forward_rotation_flag;
        logic drive_ready_flag;
        logic general_output_three;
        logic general_output_two;
        logic general_output_one;
        logic low_current_flag;
        logic heatsink_overheat_warning;
        logic starting_contact_flag;
        logic fan_speed_drop_flag;
        logic capacitor_life_warning;
        logic boolean_result_three;
        logic boolean_result_two;
        logic boolean_result_one;
        logic comm_train_lost_flag;
        logic pid_feedback_compare_flag;
        logic analog_current_input_lost_flag;
        logic analog_voltage_input_lost_flag;
        logic overload_notice_two_flag;
    } dcm_drive_s;

    typedef struct packed {
        logic sum_check_error_flag;
        logic parity_error_flag;
        logic framing_error_flag;
        logic overrun_error_flag;
        logic crc_error_flag;
    } dcm_commerr_s;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic        wdata;
    } dcm_coilreq_s;

    typedef struct packed {
        logic valid;
        logic err;
        logic data;
    } dcm_coilrsp_s;

    typedef struct packed {
        logic        valid;
        logic        wide;
        logic        high;
        logic        div100;
        logic [15:0] addr;
        logic [15:0] data;
    } dcm_regwr_s;

    typedef enum logic [1:0] {
        DCM_PAIR_IDLE = 2'b01,
        DCM_PAIR_HIGH = 2'b10
    } dcm_pair_e;

endpackage

/* File: testbench/dcm_master_model.sv */
/*
 * Behavioural network master driving the coil and register ports.
 * Assumes one clock; requests change only at the falling edge.
 */
`timescale 1ns/1ns

module dcm_master_model (
    input  wire logic                  clk,
    output dcm_pkg::dcm_coilreq_s      coilReq,
    input  wire dcm_pkg::dcm_coilrsp_s coilRsp,
    output dcm_pkg::dcm_regwr_s        regWr
);
    import dcm_pkg::*;

    initial begin
        coilReq = '0;
        regWr   = '0;
    end

    // ------------------------------------------------------------
    // Coil access
    // ------------------------------------------------------------
    // Released fields are inverted so stale values never look valid
    task automatic coil_op(input logic wr, input logic [15:0] adr,
                           input logic wd, output logic rd,
                           output logic er, output logic seen);
        int n;
        seen = 1'b0;
        @(negedge clk);
        coilReq = '{valid: 1'b1, write: wr, addr: adr, wdata: wd};
        @(negedge clk);
        coilReq = '{valid: 1'b0, write: ~wr, addr: ~adr, wdata: ~wd};
        for (n = 0; n < 3 && !seen; n++) begin
            if (coilRsp.valid === 1'b1) seen = 1'b1;
            else @(negedge clk);
        end
        rd = coilRsp.data;
        er = coilRsp.err;
    endtask

    // ------------------------------------------------------------
    // Holding register writes
    // ------------------------------------------------------------
    // Values come already scaled to integers and within range
    task automatic reg_op(input logic wd, hi, d100,
                          input logic [15:0] adr, dat);
        @(negedge clk);
        regWr = '{1'b1, wd, hi, d100, adr, dat};
        @(negedge clk);
        regWr = '{1'b0, ~wd, ~hi, ~d100, ~adr, ~dat};
    endtask

    // High half first, low half at the next address, back to back or
    // with one idle cycle between them
    task automatic reg_wide(input logic gap, d100,
                            input logic [15:0] adr,
                            input logic [31:0] val);
        @(negedge clk);
        regWr = '{1'b1, 1'b1, 1'b1, d100, adr, val[31:16]};
        if (gap) begin
            @(negedge clk);
            regWr.valid = 1'b0;
        end
        @(negedge clk);
        regWr = '{1'b1, 1'b1, 1'b0, d100, adr + 16'h0001, val[15:0]};
        @(negedge clk);
        regWr = '{1'b0, 1'b0, 1'b1, ~d100, ~adr, ~val[15:0]};
    endtask
endmodule

/* File: testbench/tb_drive_modbus_coil_map.sv */
/*
 * Self-checking bench for the drive coil map block.
 * Assumes the master model in dcm_master_model drives both request ports.
 */
`timescale 1ns/1ns

module tb_drive_modbus_coil_map;
    import dcm_pkg::*;

    logic         clk;
    logic         rst_n;
    dcm_coilreq_s coilReq;
    dcm_coilrsp_s coilRsp;
    dcm_drive_s   driveStatus;
    dcm_commerr_s commErrEvent;
    logic         errReset;
    logic [6:0]   termIn;
    logic [6:0]   termEffective;
    dcm_regwr_s   regWr;
    logic         valueValid;
    logic [15:0]  valueAddr;
    logic [31:0]  valueData;
    logic         rd;
    logic         er;
    logic         seen;
    int           errors = 0;
    int           totalChecks = 0;
    int           cycles = 0;

    dcm_coil_map uut (.clk(clk), .rst_n(rst_n), .coilReq(coilReq),
        .coilRsp(coilRsp), .driveStatus(driveStatus),
        .commErrEvent(commErrEvent), .errReset(errReset), .termIn(termIn),
        .termEffective(termEffective), .regWr(regWr),
        .valueValid(valueValid), .valueAddr(valueAddr),
        .valueData(valueData));

    dcm_master_model mst (.clk(clk), .coilReq(coilReq), .coilRsp(coilRsp),
        .regWr(regWr));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // The whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Compare and access helpers
    // ------------------------------------------------------------
    task automatic check_bit(input string what, input logic exp, got);
        totalChecks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_word(input string what, input logic [31:0] exp,
                              got);
        totalChecks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic read_coil(input logic [15:0] adr, input logic exp,
                             expErr);
        mst.coil_op(1'b0, adr, 1'b0, rd, er, seen);
        check_bit("coil read answer", 1'b1, seen);
        check_bit("coil read refused", expErr, er);
        check_bit("coil read data", exp, rd);
    endtask

    task automatic write_coil(input logic [15:0] adr, input logic wd,
                              expErr);
        mst.coil_op(1'b1, adr, wd, rd, er, seen);
        check_bit("coil write answer", 1'b1, seen);
        check_bit("coil write refused", expErr, er);
    endtask

    task automatic expect_value(input logic [15:0] adr,
                                input logic [31:0] exp);
        int n;
        seen = 1'b0;
        for (n = 0; n < 3 && !seen; n++) begin
            if (valueValid === 1'b1) seen = 1'b1;
            else @(negedge clk);
        end
        check_bit("value strobe", 1'b1, seen);
        check_word("value address", {16'h0000, adr}, {16'h0000, valueAddr});
        check_word("value data", exp, valueData);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_status_live();
        for (int k = 0; k < 2; k++) begin
            @(negedge clk);
            driveStatus = (k == 0) ? 28'hA5C_3961 : ~28'hA5C_3961;
            for (int i = 0; i < DCM_DRIVE_BITS; i++) begin
                read_coil(DCM_STAT_OFF[i], driveStatus[i], 1'b0);
            end
        end
    endtask

    task automatic test_comm_errors();
        for (int j = 0; j < 5; j++) begin
            @(negedge clk);
            commErrEvent = dcm_commerr_s'(5'h01 << j);
            @(negedge clk);
            commErrEvent = '0;
            for (int i = 0; i < 5; i++) begin
                read_coil(DCM_STAT_OFF[28 + i], i <= j, 1'b0);
            end
        end
        // Drive running while the reset arrives
        driveStatus.forward_rotation_flag = 1'b1;
        errReset = 1'b1;
        @(negedge clk);
        errReset = 1'b0;
        for (int i = 0; i < 5; i++) begin
            read_coil(DCM_STAT_OFF[28 + i], 1'b0, 1'b0);
        end
        // Event meets the reset, then is read the very next cycle
        @(negedge clk);
        errReset = 1'b1;
        commErrEvent.crc_error_flag = 1'b1;
        read_coil(DCM_STAT_OFF[28], 1'b1, 1'b0);
        errReset = 1'b0;
        commErrEvent = '0;
    endtask

    task automatic test_terminals();
        write_coil(16'h0007, 1'b1, 1'b0);
        read_coil(16'h0007, 1'b1, 1'b0);
        termIn[1] = 1'b1;
        write_coil(16'h0008, 1'b0, 1'b0);
        read_coil(16'h0008, 1'b1, 1'b0);
        write_coil(16'h000D, 1'b1, 1'b0);
        check_word("terminals", 32'h0000_0043, {25'h0, termEffective});
        termIn = 7'h01;
        @(negedge clk);
        termIn = 7'h00;
        @(negedge clk);
        read_coil(16'h0007, 1'b0, 1'b0);
        check_word("terminals", 32'h0000_0040, {25'h0, termEffective});
    endtask

    task automatic test_refusals();
        logic [15:0] bad [5] = '{16'h0030, 16'h0057, 16'h0059, 16'hFFFF,
                                 16'h0000};
        write_coil(DCM_OFF_WRITE, 1'b1, 1'b1);
        read_coil(DCM_OFF_WRITE, driveStatus[20], 1'b0);
        for (int i = 0; i < 5; i++) begin
            read_coil(bad[i], 1'b0, 1'b1);
            write_coil(bad[i], 1'b1, 1'b1);
        end
        write_coil(16'h0006, 1'b1, 1'b1);
        check_word("terminals", 32'h0000_0040, {25'h0, termEffective});
    endtask

    task automatic test_scaling();
        mst.reg_op(1'b0, 1'b0, 1'b0, 16'h0006, 16'h04D2);
        expect_value(16'h0006, 32'h0000_007B);
        mst.reg_op(1'b0, 1'b0, 1'b1, 16'h0011, 16'h9C40);
        expect_value(16'h0011, 32'h0000_0190);
        mst.reg_wide(1'b0, 1'b1, 16'h0001, 32'h0001_86A3);
        expect_value(16'h0002, 32'h0000_03E8);
        mst.reg_wide(1'b1, 1'b0, 16'h0014, 32'h0001_0000);
        expect_value(16'h0015, 32'h0000_1999);
    endtask

    task automatic give_verdict();
        if (errors == 0 && totalChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        driveStatus = '0;
        commErrEvent = '0;
        errReset = 1'b0;
        termIn = 7'h00;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        test_status_live();
        test_comm_errors();
        test_terminals();
        test_refusals();
        test_scaling();
        give_verdict();
    end
endmodule
